// *** pwdm_map.svh ***
`ifndef PWDM_MAP_SVH
`define PWDM_MAP_SVH

// Clock rate and conversion timing
`define PWDM_CLK_HZ          40000000
`define PWDM_FIRST_PULSE_NS  8000
`define PWDM_NS_PER_S        1000000000
// Cycles from sample edge to first conversion pulse (least time, rounded up)
`define PWDM_FIRST_CYC ((`PWDM_FIRST_PULSE_NS * (`PWDM_CLK_HZ / 1000000) + 999) / 1000)
// Default conversion clock period in system cycles
`define PWDM_CONV_PERIOD     40
`define PWDM_CHANNELS        4
`define PWDM_CNT_W           7
`define PWDM_CNT_MAX         7'h7f
`define PWDM_CNT_ZERO        7'h00
`define PWDM_FIFO_DEPTH      16

`endif

// *** pwdm_pkg.sv ***
package pwdm_pkg;
    typedef enum logic [1:0]
    {
        PWDM_IDLE   = 2'b00,
        PWDM_DELAY  = 2'b01,
        PWDM_COUNT  = 2'b10
    } pwdm_state_t;

    // One finished conversion: channel and raw count
    typedef struct packed
    {
        logic [1:0] chan;
        logic [6:0] count;
    } pwdm_sample_t;
endpackage

// *** pwdm_fifo.sv ***
`timescale 1ns/1ps
`include "pwdm_map.svh"

module pwdm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = `PWDM_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_arst_n,
    // Write side
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    input  wire logic [WIDTH-1:0] i_wr_data,
    // Read side
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic [WIDTH-1:0]      o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      fill_reg;
    wire              do_wr;
    wire              do_rd;

    assign o_wr_ready = (fill_reg != (AW+1)'(DEPTH));
    assign o_rd_valid = (fill_reg != '0);
    assign do_wr      = i_wr_valid && o_wr_ready;
    assign do_rd      = o_rd_valid && i_rd_ready;
    assign o_rd_data  = mem[rd_ptr_reg];

    always_ff @(posedge i_clk)
    begin
        if (do_wr)
            mem[wr_ptr_reg] <= i_wr_data;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            fill_reg   <= '0;
        end
        else
        begin
            if (do_wr)
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            if (do_rd)
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            fill_reg <= fill_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule // pwdm_fifo

// *** pwdm_demod.sv ***
// What this block does
// (RULE1) A rising sample command starts the conversion clock and clears the counter.
// (RULE2) The first conversion pulse comes 8 us after the rising sample command.
// (RULE3) The instrument raises its pulse-width signal 3 us after the sample command.
// (RULE4) The falling pulse-width edge copies the counter into a storage register.
// (RULE5) One shared 7-bit counter feeds four independent 7-bit storage registers.
// (RULE6) Each channel presents its seven stored bits in parallel to its ladder.
// (RULE7) Output is inverted so a count of 127 gives the lowest level, 0 the highest.
// (RULE8) The counter advances per conversion pulse only while the pulse is high, stopping at 127.
`timescale 1ns/1ps
`include "pwdm_map.svh"

module pwdm_demod #(
    parameter int CONV_PERIOD = `PWDM_CONV_PERIOD,
    parameter int FIRST_CYC   = `PWDM_FIRST_CYC,
    parameter int FIFO_DEPTH  = `PWDM_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_arst_n,
    // Instrument side
    input  wire logic                   i_sample,
    input  wire logic [1:0]             i_chan_sel,
    input  wire logic                   i_pulse,
    // Ladder drivers, one 7-bit word per channel
    output logic [`PWDM_CHANNELS*`PWDM_CNT_W-1:0] o_ladder,
    // Recorded conversions
    output logic                        o_rec_valid,
    input  wire logic                   i_rec_ready,
    output pwdm_pkg::pwdm_sample_t      o_rec_data,
    // Status
    output logic                        o_busy,
    output logic                        o_overrun
);
    pwdm_pkg::pwdm_state_t state_reg;
    pwdm_pkg::pwdm_state_t state_next;
    logic [15:0]              tick_reg;
    logic [`PWDM_CNT_W-1:0]   count_reg;
    logic [1:0]               chan_reg;
    logic                     sample_d_reg;
    logic                     pulse_d_reg;
    logic                     overrun_reg;
    logic [`PWDM_CNT_W-1:0]   store_reg [`PWDM_CHANNELS];
    pwdm_pkg::pwdm_sample_t   rec_word;

    wire sample_rise = i_sample && !sample_d_reg;
    wire pulse_fall  = !i_pulse && pulse_d_reg;
    wire first_hit   = (state_reg == pwdm_pkg::PWDM_DELAY) && (tick_reg == 16'(FIRST_CYC - 1));
    wire period_hit  = (state_reg == pwdm_pkg::PWDM_COUNT) && (tick_reg == 16'(CONV_PERIOD - 1));
    wire conv_pulse  = first_hit || period_hit;
    wire at_max      = (count_reg == `PWDM_CNT_MAX);
    wire capture     = pulse_fall && (state_reg != pwdm_pkg::PWDM_IDLE);
    wire fifo_ready;

    assign o_busy    = (state_reg != pwdm_pkg::PWDM_IDLE);
    assign o_overrun = overrun_reg;
    assign rec_word  = '{chan: chan_reg, count: count_reg};

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            pwdm_pkg::PWDM_IDLE:  state_next = state_reg;
            pwdm_pkg::PWDM_DELAY: if (first_hit) state_next = pwdm_pkg::PWDM_COUNT;
            pwdm_pkg::PWDM_COUNT: state_next = state_reg;
            default:              state_next = pwdm_pkg::PWDM_IDLE;
        endcase
        // (RULE1) Sample edge restarts conversion
        if (sample_rise)
            state_next = pwdm_pkg::PWDM_DELAY;
        else if (capture)
            state_next = pwdm_pkg::PWDM_IDLE;
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_reg    <= pwdm_pkg::PWDM_IDLE;
            sample_d_reg <= 1'b0;
            pulse_d_reg  <= 1'b0;
            chan_reg     <= 2'h0;
            overrun_reg  <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            sample_d_reg <= i_sample;
            pulse_d_reg  <= i_pulse;
            if (sample_rise)
                chan_reg <= i_chan_sel;
            if (capture && !fifo_ready)
                overrun_reg <= 1'b1;
        end
    end

    // (RULE2) First pulse after fixed delay, then periodic
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            tick_reg <= 16'h0000;
        else if (sample_rise || conv_pulse)
            tick_reg <= 16'h0000;
        else if (o_busy)
            tick_reg <= tick_reg + 16'h0001;
    end

    // (RULE8) Count only while pulse high, hold at max
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            count_reg <= `PWDM_CNT_ZERO;
        else if (sample_rise)
            count_reg <= `PWDM_CNT_ZERO;
        else if (conv_pulse && i_pulse && !at_max)
            count_reg <= count_reg + 7'h01;
    end

    // (RULE5) Four independent storage registers
    genvar g;
    generate
        for (g = 0; g < `PWDM_CHANNELS; g++)
        begin : g_store
            // (RULE4) Falling pulse edge latches count
            always_ff @(posedge i_clk or negedge i_arst_n)
            begin
                if (!i_arst_n)
                    store_reg[g] <= `PWDM_CNT_ZERO;
                else if (capture && chan_reg == 2'(g))
                    store_reg[g] <= count_reg;
            end
            // (RULE6) (RULE7) Seven inverted bits per ladder
            assign o_ladder[g*`PWDM_CNT_W +: `PWDM_CNT_W] = ~store_reg[g];
        end
    endgenerate

    pwdm_fifo #(
        .WIDTH ($bits(pwdm_pkg::pwdm_sample_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clk      (i_clk),
        .i_arst_n   (i_arst_n),
        .i_wr_valid (capture),
        .o_wr_ready (fifo_ready),
        .i_wr_data  (rec_word),
        .o_rd_valid (o_rec_valid),
        .i_rd_ready (i_rec_ready),
        .o_rd_data  (o_rec_data)
    );
endmodule // pwdm_demod

// *** pwdm_chk_sva.sv ***
`timescale 1ns/1ps
module pwdm_chk (
    // Watched ports
    input wire logic                   i_clk,
    input wire logic                   i_arst_n,
    input wire logic                   i_sample,
    input wire logic                   i_pulse,
    input wire logic                   i_rec_ready,
    input wire logic [27:0]            o_ladder,
    input wire logic                   o_rec_valid,
    input wire pwdm_pkg::pwdm_sample_t o_rec_data,
    input wire logic                   o_busy,
    input wire logic                   o_overrun
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    property p_start; i_sample && !$past(i_sample) |=> o_busy; endproperty
    property p_cap;
        o_busy && $fell(i_pulse) && !(i_sample && !$past(i_sample)) |=> !o_busy && o_rec_valid;
    endproperty
    property p_hold; o_busy && i_pulse |=> o_busy; endproperty
    property p_idle; !o_busy && !i_sample |=> !o_busy; endproperty
    property p_lad; !o_busy |=> $stable(o_ladder); endproperty
    property p_rv; o_rec_valid && !i_rec_ready |=> o_rec_valid; endproperty
    property p_rd; o_rec_valid && !i_rec_ready |=> $stable(o_rec_data); endproperty
    property p_ovr; o_overrun |=> o_overrun; endproperty
    a_start: assert property (p_start) else $error("no start");
    a_cap: assert property (p_cap) else $error("no capture");
    a_hold: assert property (p_hold) else $error("early end");
    a_idle: assert property (p_idle) else $error("stray start");
    a_lad: assert property (p_lad) else $error("ladder moved");
    a_rv: assert property (p_rv) else $error("record lost");
    a_rd: assert property (p_rd) else $error("record moved");
    a_ovr: assert property (p_ovr) else $error("overrun cleared");
    c_cap: cover property (o_busy && $fell(i_pulse));
    c_pop: cover property (o_rec_valid && i_rec_ready);
    c_ovr: cover property ($rose(o_overrun));
endmodule // pwdm_chk
bind pwdm_demod pwdm_chk u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sample(i_sample),
    .i_pulse(i_pulse), .i_rec_ready(i_rec_ready), .o_ladder(o_ladder),
    .o_rec_valid(o_rec_valid), .o_rec_data(o_rec_data), .o_busy(o_busy), .o_overrun(o_overrun));

// *** pwdm_instr.sv ***
`timescale 1ns/1ps
module pwdm_instr #(parameter int LEAD = 120) (
    // Clock and command
    input  wire logic        i_clk,
    input  wire logic        i_sample,
    input  wire logic [15:0] i_width,
    // Flux pulse
    output logic             o_pulse
);
    logic smp_reg = 1'b0;
    int   tick = -1;
    always @(posedge i_clk)
    begin
        smp_reg <= i_sample;
        if (i_sample && !smp_reg)
            tick <= 0;
        else if (tick >= 0 && tick < LEAD + i_width)
            tick <= tick + 1;
        else
            tick <= -1;
    end
    assign o_pulse = (tick >= LEAD) && (tick < LEAD + i_width);
endmodule // pwdm_instr

// *** pwdm_demod_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module pwdm_demod_tb;
    logic                   i_clk = 1'b0;
    logic                   i_arst_n = 1'b0;
    logic                   i_sample = 1'b0;
    logic [1:0]             i_chan_sel = 2'h0;
    logic                   i_pulse;
    logic                   i_rec_ready = 1'b0;
    logic [27:0]            o_ladder;
    logic                   o_rec_valid;
    logic                   o_busy;
    logic                   o_overrun;
    logic [15:0]            lfsr = 16'hab03;
    logic [15:0]            width = 16'h0;
    int                     err_count = 0;
    int                     checks_done = 0;
    pwdm_pkg::pwdm_sample_t o_rec_data;
    pwdm_pkg::pwdm_sample_t e;
    pwdm_pkg::pwdm_sample_t exp_q[$];
    always #12.5 i_clk = ~i_clk;
    pwdm_instr #(.LEAD(120)) u_ins (.i_clk(i_clk), .i_sample(i_sample), .i_width(width),
        .o_pulse(i_pulse));
    pwdm_demod #(.CONV_PERIOD(4)) uut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sample(i_sample),
        .i_chan_sel(i_chan_sel), .i_pulse(i_pulse), .o_ladder(o_ladder),
        .o_rec_valid(o_rec_valid), .i_rec_ready(i_rec_ready), .o_rec_data(o_rec_data),
        .o_busy(o_busy), .o_overrun(o_overrun));
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Pulse ends two cycles past tick n, so count is n+1
    task automatic conv(input logic [1:0] ch, input int n);
        logic [6:0] cnt;
        cnt = (n < 0) ? 7'h00 : (n > 125) ? 7'h7f : 7'(n + 1);
        width = (n < 0) ? 16'h96 : 16'(202 + 4 * n);
        i_chan_sel = ch;
        i_sample = 1'b1;
        @(posedge i_clk) #1 i_sample = 1'b0;
        for (int k = 0; k < 1500 && o_busy !== 1'b0; k++) @(posedge i_clk) #1;
        `CHK("busy_end", 1'b0, o_busy)
        `CHK("ladder", ~cnt, o_ladder[ch * 7 +: 7])
        if (exp_q.size() < 16) exp_q.push_back({ch, cnt});
        else `CHK("overrun", 1'b1, o_overrun)
    endtask
    always @(posedge i_clk)
    begin
        if (o_rec_valid === 1'b1 && i_rec_ready === 1'b1)
        begin
            e = exp_q.size() ? exp_q.pop_front() : 'x;
            `CHK("record", e, o_rec_data)
        end
    end
    initial
    begin
        repeat (12) @(posedge i_clk);
        `CHK("rst_ladder", 28'hfffffff, o_ladder)
        #1 i_arst_n = 1'b1;
        i_rec_ready = 1'b1;
        conv(2'h1, -1);
        conv(2'h2, 200);
        conv(2'h2, 0);
        for (int c = 0; c < 4; c++) conv(c[1:0], c * 41);
        for (int c = 0; c < 4; c++) `CHK("chan", ~7'(c * 41 + 1), o_ladder[c * 7 +: 7])
        $display("test fixed done");
        repeat (6)
        begin
            lfsr = nxt(lfsr);
            conv(lfsr[1:0], lfsr[15:8]);
        end
        $display("test random done");
        i_rec_ready = 1'b0;
        repeat (17)
        begin
            lfsr = nxt(lfsr);
            conv(lfsr[1:0], lfsr[4:0]);
        end
        i_rec_ready = 1'b1;
        repeat (20) @(posedge i_clk);
        `CHK("empty", 1'b0, o_rec_valid)
        `CHK("queue", 0, exp_q.size())
        $display("test fifo done");
        stop_test();
    end
    initial
    begin
        #2000000;
        `CHK("timeout", 1'b0, 1'b1)
        stop_test();
    end
endmodule // pwdm_demod_tb
